/* File: hw/bsr_conv.sv */
// shared converter: paced by master clock ticks, latches one raw result
// assumes mclk_tick is a one-cycle pulse and raw inputs are on sys_clk
`default_nettype none
module bsr_conv
   import bsr_pkg::*;
#(
   parameter logic [10:0] CONV_TICKS = 11'(CONV_MCLK_TICKS)
) (
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   input  wire logic          mclk_tick,
   input  wire logic          start,
   input  wire logic          sel_temp,
   input  wire bsr_word_t     raw_pressure_result,
   input  wire bsr_word_t     raw_temperature_result,
   output logic               busy,
   output bsr_word_t          result
);
   import bsr_pkg::*;
   logic        busy_ff;
   logic        temp_ff;
   logic [10:0] tick_ff;
   bsr_word_t   res_ff;
   wire logic   last_tick = busy_ff && mclk_tick && (tick_ff == CONV_TICKS - 11'h001);
   // ---------------------------------------------------------------
   // conversion timer
   // ---------------------------------------------------------------
   // a start while busy is ignored; the host must drain the last result first
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_ff <= 1'b0;
         temp_ff <= 1'b0;
         tick_ff <= 11'h000;
      end else if (start && !busy_ff) begin
         busy_ff <= 1'b1;
         temp_ff <= sel_temp;
         tick_ff <= 11'h000;
      end else if (last_tick) begin
         busy_ff <= 1'b0; // see [RULE23]
      end else if (busy_ff && mclk_tick) begin
         tick_ff <= tick_ff + 11'h001;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         res_ff <= WORD_RST;
      end else if (last_tick) begin
         res_ff <= temp_ff ? raw_temperature_result : raw_pressure_result; // see [RULE1]
      end
   end
   assign busy   = busy_ff;
   assign result = res_ff;
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_conv_bound: assert property (busy_ff |-> tick_ff < CONV_TICKS) // see [RULE23]
      else $error("conversion ran past its tick budget");
   a_result_select: assert property ($fell(busy_ff) && temp_ff |-> // see [RULE1]
      res_ff == $past(raw_temperature_result))
      else $error("temperature result not latched");
endmodule
`default_nettype wire

/* File: hw/bsr_pkg.sv */
// shared constants, types and helpers of the barometer serial readout
// assumes one system clock; pins are synchronised in the top module
`default_nettype none
package bsr_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CONV_TIME_US    = 35000;
   localparam int unsigned MCLK_HZ         = 32768;
   // longest time, so the count rounds down
   localparam int unsigned CONV_MCLK_TICKS = (CONV_TIME_US * MCLK_HZ) / 1000000;
   localparam int unsigned ACK_CLOCKS      = 2;
   localparam int unsigned READ_CLOCKS     = 17;
   // ---------------------------------------------------------------
   // frame layout
   // ---------------------------------------------------------------
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned CMD_W   = 4;
   localparam int unsigned HIST_W  = 21;
   localparam int unsigned FRAME_W = 10;
   localparam logic [2:0]  START_BITS = 3'h7;
   localparam logic [2:0]  STOP_BITS  = 3'h0;
   localparam logic [HIST_W-1:0] HIST_RST = 21'h000000;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [4:0]        CNT_RST  = 5'h00;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      BSR_IDLE = 2'h0,
      BSR_ACK  = 2'h1,
      BSR_CONV = 2'h3,
      BSR_READ = 2'h2
   } bsr_state_e;
   typedef struct packed {
      logic sclk;
      logic din;
      logic mclk;
   } bsr_pins_s;
   localparam bsr_pins_s PINS_RST = '{sclk: 1'b0, din: 1'b0, mclk: 1'b0};
   typedef logic [WORD_W-1:0] bsr_word_t;
   // ---------------------------------------------------------------
   // calibration word packing
   // ---------------------------------------------------------------
   function automatic bsr_word_t calib_pack(input logic [1:0]  idx,
                                            input logic [14:0] c1,
                                            input logic [11:0] c2,
                                            input logic [9:0]  c3,
                                            input logic [9:0]  c4,
                                            input logic [10:0] c5,
                                            input logic [5:0]  c6);
      case (idx)
         2'h0:    calib_pack = {c1, c5[10]};
         2'h1:    calib_pack = {c5[9:0], c6};
         2'h2:    calib_pack = {c4, c2[11:6]};
         default: calib_pack = {c3, c2[5:0]};
      endcase
   endfunction
endpackage
`default_nettype wire

/* File: hw/bsr_top.sv */
// serial readout of a pressure and temperature sensor module
// assumes sclk, din and mclk are asynchronous pins, sclk under 500 kHz
`default_nettype none
// Summary of operation
// [RULE1] results are unsigned 16-bit, pressure or temperature, one shared converter
// [RULE2] four readable 16-bit calibration words hold six coefficients
// [RULE3] first and second calibration words pack coefficients one, five, six
// [RULE4] third and fourth words pack coefficients four, three and two
// [RULE5] input sampled and output updated on rising serial clock
// [RULE6] host changes input and samples output on falling serial clock
// [RULE7] host alone makes the serial clock
// [RULE8] command framed by three high and three low bits
// [RULE9] command field is four bits choosing conversion or calibration word
// [RULE10] output carries result or word chosen by last command, plus status
// [RULE11] seven sequences: two conversions, four word reads, reset
// [RULE12] accepted conversion acknowledged by output going high
// [RULE13] host gives two clocks after acknowledge then idles clock low
// [RULE14] end of conversion shown by output going low
// [RULE15] seventeen clocks after conversion end shift out the 16-bit result
// [RULE16] stalled serial clock pauses readout without losing position
// [RULE17] host reads previous result before starting a new conversion
// [RULE18] 21-bit reset pattern returns to idle from any state
// [RULE19] host ignores output while sending the reset pattern
// [RULE20] host should send reset pattern before each conversion
// [RULE21] host reads calibration words once after its own reset
// [RULE22] host starts every transaction; device never starts one
// [RULE23] conversion completes within 35 ms at 32.768 kHz master clock
// [RULE24] master clock may stop in standby without losing protocol state
// [RULE25] command codes and reset pattern are parameters
// [RULE26] output held low outside acknowledge, conversion and readout
module bsr_top
   import bsr_pkg::*;
#(
   parameter logic [CMD_W-1:0]  CMD_PRESS  = 4'ha, // see [RULE25]
   parameter logic [CMD_W-1:0]  CMD_TEMP   = 4'h9,
   parameter logic [CMD_W-1:0]  CMD_CALIB_FIRST_WORD  = 4'h5,
   parameter logic [CMD_W-1:0]  CMD_CALIB_SECOND_WORD  = 4'h6,
   parameter logic [CMD_W-1:0]  CMD_CALIB_THIRD_WORD  = 4'h3,
   parameter logic [CMD_W-1:0]  CMD_CALIB_FOURTH_WORD  = 4'hc,
   parameter logic [HIST_W-1:0] RST_PATTERN = 21'h1555a0,
   parameter logic [10:0]       CONV_TICKS = 11'(CONV_MCLK_TICKS),
   // factory coefficients; the defaults are arbitrary
   parameter logic [14:0]       COEF_ONE   = 15'h1234,
   parameter logic [11:0]       COEF_TWO   = 12'h9a5,
   parameter logic [9:0]        COEF_THREE = 10'h2c3,
   parameter logic [9:0]        COEF_FOUR  = 10'h13e,
   parameter logic [10:0]       COEF_FIVE  = 11'h5a6,
   parameter logic [5:0]        COEF_SIX   = 6'h2b
) (
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   input  wire logic          sclk,
   input  wire logic          din,
   input  wire logic          mclk,
   input  wire bsr_word_t     raw_pressure_result,
   input  wire bsr_word_t     raw_temperature_result,
   output logic               dout
);
   import bsr_pkg::*;
   // ---------------------------------------------------------------
   // pin synchronisers and edge finders
   // ---------------------------------------------------------------
   bsr_pins_s pins_meta_ff;
   bsr_pins_s pins_sync_ff;
   bsr_pins_s pins_prev_ff;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pins_meta_ff <= PINS_RST;
         pins_sync_ff <= PINS_RST;
         pins_prev_ff <= PINS_RST;
      end else begin
         pins_meta_ff <= '{sclk: sclk, din: din, mclk: mclk};
         pins_sync_ff <= pins_meta_ff;
         pins_prev_ff <= pins_sync_ff;
      end
   end
   // din moves on the falling edge, so it is settled at the rising one
   wire logic sclk_rise = pins_sync_ff.sclk && !pins_prev_ff.sclk; // see [RULE5]
   wire logic mclk_tick = pins_sync_ff.mclk && !pins_prev_ff.mclk;
   wire logic din_bit   = pins_sync_ff.din;
   // ---------------------------------------------------------------
   // bit history and command decode
   // ---------------------------------------------------------------
   logic [HIST_W-1:0] hist_ff;
   wire logic [HIST_W-1:0]  nxt_hist  = {hist_ff[HIST_W-2:0], din_bit};
   wire logic [CMD_W-1:0]   cmd_field = nxt_hist[FRAME_W-4:3];
   wire logic               framed    = (nxt_hist[FRAME_W-1:FRAME_W-3] == START_BITS)
                                        && (nxt_hist[2:0] == STOP_BITS); // see [RULE8]
   wire logic rst_hit  = sclk_rise && (nxt_hist == RST_PATTERN); // see [RULE18]
   wire logic is_press = (cmd_field == CMD_PRESS);
   wire logic is_temp  = (cmd_field == CMD_TEMP);
   wire logic is_w1    = (cmd_field == CMD_CALIB_FIRST_WORD);
   wire logic is_w2    = (cmd_field == CMD_CALIB_SECOND_WORD);
   wire logic is_w3    = (cmd_field == CMD_CALIB_THIRD_WORD);
   wire logic is_w4    = (cmd_field == CMD_CALIB_FOURTH_WORD);
   wire logic is_word  = is_w1 || is_w2 || is_w3 || is_w4; // see [RULE9]
   wire logic [1:0] word_idx = is_w1 ? 2'h0 : is_w2 ? 2'h1 : is_w3 ? 2'h2 : 2'h3;
   // ---------------------------------------------------------------
   // protocol state
   // ---------------------------------------------------------------
   bsr_state_e state_ff;
   bsr_state_e nxt_state;
   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;
   bsr_word_t  shreg_ff;
   bsr_word_t  nxt_shreg;
   logic       dout_ff;
   logic       nxt_dout;
   wire logic  idle_rise  = sclk_rise && !rst_hit && (state_ff == BSR_IDLE) && framed;
   wire logic  conv_cmd   = idle_rise && (is_press || is_temp); // see [RULE11]
   wire logic  word_cmd   = idle_rise && is_word;
   wire logic  conv_busy;
   bsr_word_t  conv_result;
   wire bsr_word_t calib_word = calib_pack(word_idx, COEF_ONE, COEF_TWO, COEF_THREE,
                                           COEF_FOUR, COEF_FIVE, COEF_SIX); // see [RULE2]
   wire logic  conv_end   = (state_ff == BSR_CONV) && !conv_busy;
   wire logic  read_last  = (cnt_ff == 5'(READ_CLOCKS - 1));
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_shreg = shreg_ff;
      nxt_dout  = dout_ff;
      if (rst_hit) begin
         nxt_state = BSR_IDLE; // see [RULE18]
         nxt_cnt   = CNT_RST;
         nxt_dout  = 1'b0;
      end else begin
         case (state_ff)
            BSR_IDLE: begin
               nxt_dout = 1'b0; // see [RULE26]
               if (conv_cmd) begin
                  nxt_state = BSR_ACK;
                  nxt_cnt   = CNT_RST;
                  nxt_dout  = 1'b1; // see [RULE12]
               end else if (word_cmd) begin
                  nxt_state = BSR_READ; // see [RULE10]
                  nxt_cnt   = CNT_RST;
                  nxt_shreg = calib_word; // see [RULE3] see [RULE4]
               end
            end
            BSR_ACK: begin
               if (sclk_rise) begin
                  nxt_cnt = cnt_ff + 5'h01;
                  if (cnt_ff == 5'(ACK_CLOCKS - 1)) begin
                     nxt_state = BSR_CONV;
                  end
               end
            end
            BSR_CONV: begin
               // sclk edges here only shift the history for the reset pattern; the host should hold it low
               if (conv_end) begin
                  nxt_state = BSR_READ;
                  nxt_cnt   = CNT_RST;
                  nxt_dout  = 1'b0; // see [RULE14]
                  nxt_shreg = conv_result; // see [RULE10]
               end
            end
            BSR_READ: begin
               // no edge, no move: a stalled clock just pauses here
               if (sclk_rise) begin // see [RULE16]
                  nxt_cnt = cnt_ff + 5'h01;
                  if (read_last) begin
                     nxt_state = BSR_IDLE; // see [RULE15]
                     nxt_dout  = 1'b0;
                  end else begin
                     nxt_dout  = shreg_ff[WORD_W-1]; // see [RULE5]
                     nxt_shreg = {shreg_ff[WORD_W-2:0], 1'b0};
                  end
               end
            end
            default: begin
               nxt_state = BSR_IDLE;
               nxt_dout  = 1'b0;
            end
         endcase
      end
   end
   // the history is cleared after a reset pattern so stale bits never frame
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hist_ff <= HIST_RST;
      end else if (rst_hit) begin
         hist_ff <= HIST_RST;
      end else if (sclk_rise) begin
         hist_ff <= nxt_hist;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= BSR_IDLE;
         cnt_ff   <= CNT_RST;
         shreg_ff <= WORD_RST;
         dout_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         shreg_ff <= nxt_shreg;
         dout_ff  <= nxt_dout;
      end
   end
   assign dout = dout_ff;
   // ---------------------------------------------------------------
   // converter
   // ---------------------------------------------------------------
   // protocol state lives on sys_clk, so a stopped mclk only freezes
   // the timer and never disturbs the serial side
   bsr_conv #(
      .CONV_TICKS (CONV_TICKS)
   ) u_conv (
      .sys_clk                (sys_clk),
      .rst_b                  (rst_b),
      .mclk_tick              (mclk_tick), // see [RULE24]
      .start                  (conv_cmd),
      .sel_temp               (is_temp),
      .raw_pressure_result    (raw_pressure_result),
      .raw_temperature_result (raw_temperature_result),
      .busy                   (conv_busy),
      .result                 (conv_result)
   );
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_ack_rise: assert property (conv_cmd |=> dout && state_ff == BSR_ACK) // see [RULE12]
      else $error("conversion command not acknowledged");
   a_eoc_fall: assert property (state_ff == BSR_CONV ##1 state_ff == BSR_READ // see [RULE14]
      |-> $fell(dout))
      else $error("end of conversion not shown by falling output");
   a_idle_low: assert property (state_ff == BSR_IDLE |-> !dout) // see [RULE26]
      else $error("output high while idle");
   a_reset_idle: assert property (rst_hit |=> state_ff == BSR_IDLE && hist_ff == HIST_RST) // see [RULE18]
      else $error("reset pattern did not return to idle");
   a_dout_edge: assert property ($changed(dout) |-> $past(sclk_rise) || $past(conv_end)) // see [RULE5]
      else $error("output moved without a rising serial clock");
   a_read_hold: assert property (state_ff == BSR_READ && !sclk_rise && !rst_hit // see [RULE16]
      |=> $stable(cnt_ff) && $stable(dout) && $stable(shreg_ff))
      else $error("readout moved without a clock");
   a_read_len: assert property (state_ff == BSR_READ && sclk_rise && read_last && !rst_hit // see [RULE15]
      |=> state_ff == BSR_IDLE)
      else $error("readout did not end after seventeen clocks");
   a_word_load: assert property (word_cmd && is_w1 // see [RULE3]
      |=> shreg_ff == {COEF_ONE, COEF_FIVE[10]})
      else $error("first calibration word misassembled");
   a_ack_count: assert property (state_ff == BSR_ACK && sclk_rise && cnt_ff == 5'h01 && !rst_hit // see [RULE13]
      |=> state_ff == BSR_CONV)
      else $error("acknowledge phase length wrong");
   a_frame_only: assert property ($past(state_ff) == BSR_IDLE && state_ff != BSR_IDLE // see [RULE8]
      |-> $past(sclk_rise && framed))
      else $error("command accepted outside framing");
   c_press_conv: cover property (conv_cmd && is_press ##[1:1000] conv_end);
   c_temp_conv:  cover property (conv_cmd && is_temp);
   c_word_read:  cover property (word_cmd ##[1:1000] state_ff == BSR_IDLE);
   c_reset_hit:  cover property (rst_hit && state_ff == BSR_CONV);
endmodule
`default_nettype wire

/* File: tb/bsr_host.sv */
// host model for the three-wire link: drives sclk and din, samples dout
// assumes a 125 MHz sys_clk; half a serial period is ten of its cycles
`default_nettype none
module bsr_host
   import bsr_pkg::*;
#(
   parameter logic [HIST_W-1:0] RST_PATTERN = 21'h1555a0
) (
   input  wire logic  sys_clk,
   input  wire logic  dout,
   output var  logic  sclk,
   output var  logic  din
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // bit level
   // ---------------------------------------------------------------
   // sclk rests low outside transfers; only this model ever moves it
   initial begin
      sclk = 1'b0;
      din  = 1'b0;
   end
   task automatic half_period();
      repeat (10) @(posedge sys_clk);
      #1;
   endtask
   // din moves as sclk falls; dout is taken in the same falling moment
   task automatic clock_bit(input logic b, output logic s);
      din = b;
      half_period();
      sclk = 1'b1;
      half_period();
      s    = dout;
      sclk = 1'b0;
   endtask
   // ---------------------------------------------------------------
   // sequences
   // ---------------------------------------------------------------
   // every transaction opens with a framed command from this side
   task automatic send_cmd(input logic [CMD_W-1:0] code, output logic last_s);
      logic [FRAME_W-1:0] f = {START_BITS, code, STOP_BITS};
      for (int i = FRAME_W - 1; i >= 0; i--) begin
         clock_bit(f[i], last_s);
      end
   endtask
   // dout may toggle here, so its samples are thrown away
   task automatic send_reset();
      logic s;
      for (int i = HIST_W - 1; i >= 0; i--) begin
         clock_bit(RST_PATTERN[i], s);
      end
   endtask
   // two clocks after the acknowledge, then sclk is left low
   task automatic ack_clocks(output logic held);
      logic s1;
      logic s2;
      clock_bit(1'b0, s1);
      clock_bit(1'b0, s2);
      held = s1 & s2;
   endtask
   task automatic wait_eoc(input int bound, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < bound && !ok; i++) begin
         @(posedge sys_clk);
         #1;
         if (dout === 1'b0) ok = 1'b1;
      end
   endtask
   // seventeen clocks; sclk may stall after bit pause_at
   task automatic read_word(input int pause_at, output bsr_word_t w, output logic tail);
      logic s;
      for (int i = 0; i < READ_CLOCKS; i++) begin
         clock_bit(1'b0, s);
         if (i < WORD_W) w[WORD_W-1-i] = s;
         else tail = s;
         if (i == pause_at) begin
            repeat (60) @(posedge sys_clk);
            #1;
         end
      end
   endtask
endmodule
`default_nettype wire

/* File: tb/bsr_top_test.sv */
// self-checking bench of the serial readout with a host model on the link
// assumes the host model in bsr_host.sv and a shortened conversion count
`default_nettype none
module bsr_top_test
   import bsr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // setup
   // ---------------------------------------------------------------
   localparam logic [3:0]  CP = 4'ha;
   localparam logic [3:0]  CT = 4'h9;
   localparam logic [3:0]  W_CODE [4] = '{4'h5, 4'h6, 4'h3, 4'hc};
   localparam logic [14:0] C1 = 15'h6a5b;
   localparam logic [11:0] C2 = 12'h3c7;
   localparam logic [9:0]  C3 = 10'h155;
   localparam logic [9:0]  C4 = 10'h2aa;
   localparam logic [10:0] C5 = 11'h4e1;
   localparam logic [5:0]  C6 = 6'h19;
   localparam bsr_word_t   W_EXP [4] = '{{C1, C5[10]}, {C5[9:0], C6},
                                         {C4, C2[11:6]}, {C3, C2[5:0]}};
   // four ticks of 24 cycles each, plus one period for phase
   localparam int          EOC_BOUND = 120;
   logic      sys_clk;
   logic      rst_b;
   logic      mclk;
   logic      mclk_run;
   bsr_word_t raw_p;
   bsr_word_t raw_t;
   wire logic sclk;
   wire logic din;
   wire logic dout;
   int        error_cnt;
   int        compares;
   bsr_top #(.CMD_PRESS(CP), .CMD_TEMP(CT), .CMD_CALIB_FIRST_WORD(W_CODE[0]), .CMD_CALIB_SECOND_WORD(W_CODE[1]),
      .CMD_CALIB_THIRD_WORD(W_CODE[2]), .CMD_CALIB_FOURTH_WORD(W_CODE[3]), .CONV_TICKS(11'h004),
      .COEF_ONE(C1), .COEF_TWO(C2), .COEF_THREE(C3), .COEF_FOUR(C4), .COEF_FIVE(C5),
      .COEF_SIX(C6)) bsr_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk),
      .din(din), .mclk(mclk), .raw_pressure_result(raw_p),
      .raw_temperature_result(raw_t), .dout(dout));
   bsr_host bsr_host_inst (.sys_clk(sys_clk), .dout(dout), .sclk(sclk), .din(din));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // master clock of 192 ns that the bench may halt
   initial begin
      mclk = 1'b0;
      forever begin
         repeat (12) @(posedge sys_clk);
         #1;
         if (mclk_run) mclk = ~mclk;
      end
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input string what, input bsr_word_t exp, input bsr_word_t got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic finish_conv(input bsr_word_t exp);
      logic      ok;
      logic      tail;
      bsr_word_t w;
      bsr_host_inst.wait_eoc(EOC_BOUND, ok);
      chk("end of conversion", 16'h0001, 16'(ok));
      if (ok !== 1'b1) tally_and_finish();
      bsr_host_inst.read_word(-1, w, tail);
      chk("result", exp, w);
      chk("tail bit", 16'h0000, 16'(tail));
   endtask
   // the whole result is read before the next start
   task automatic do_conv(input logic [3:0] code, input bsr_word_t exp);
      logic ack;
      logic held;
      bsr_host_inst.send_cmd(code, ack);
      chk("acknowledge", 16'h0001, 16'(ack));
      bsr_host_inst.ack_clocks(held);
      chk("ack level", 16'h0001, 16'(held));
      finish_conv(exp);
   endtask
   task automatic read_calib(input int n, input int pause_at);
      logic      s;
      logic      tail;
      bsr_word_t w;
      bsr_host_inst.send_cmd(W_CODE[n], s);
      chk("word no ack", 16'h0000, 16'(s));
      bsr_host_inst.read_word(pause_at, w, tail);
      chk("calibration word", W_EXP[n], w);
      chk("word tail", 16'h0000, 16'(tail));
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_bad_code();
      logic      s;
      logic      tail;
      bsr_word_t w;
      // a code of all ones followed by the zeros of the readout would
      // frame a real command two bits later, so such codes are avoided
      logic [3:0] bad [2] = '{4'h0, 4'h7};
      chk("idle dout", 16'h0000, 16'(dout));
      foreach (bad[i]) begin
         bsr_host_inst.send_cmd(bad[i], s);
         bsr_host_inst.read_word(-1, w, tail);
         chk("unknown code output", 16'h0000, w);
      end
      $display("test bad_code done");
   endtask
   task automatic t_calib();
      for (int n = 0; n < 4; n++) read_calib(n, -1);
      $display("test calib done");
   endtask
   task automatic t_conv();
      bsr_host_inst.send_reset();
      do_conv(CP, raw_p);
      do_conv(CT, raw_t);
      $display("test conv done");
   endtask
   task automatic t_pause();
      read_calib(2, 7);
      $display("test pause done");
   endtask
   task automatic t_reset_mid();
      logic s;
      bsr_host_inst.send_cmd(W_CODE[0], s);
      repeat (5) bsr_host_inst.clock_bit(1'b0, s);
      bsr_host_inst.send_reset();
      chk("dout after reset", 16'h0000, 16'(dout));
      read_calib(1, -1);
      repeat (3) bsr_host_inst.clock_bit(1'b1, s);
      bsr_host_inst.send_reset();
      read_calib(3, -1);
      $display("test reset_mid done");
   endtask
   task automatic t_mclk_stop();
      logic ack;
      logic held;
      int   lows = 0;
      mclk_run = 1'b0;
      read_calib(0, -1);
      bsr_host_inst.send_cmd(CP, ack);
      bsr_host_inst.ack_clocks(held);
      chk("ack with mclk stopped", 16'h0001, 16'(ack & held));
      repeat (200) begin
         @(posedge sys_clk);
         #1;
         if (dout !== 1'b1) lows++;
      end
      chk("early end count", 16'h0000, 16'(lows));
      mclk_run = 1'b1;
      finish_conv(raw_p);
      // a reset pattern in mid-conversion must drop the acknowledge level
      mclk_run = 1'b0;
      bsr_host_inst.send_cmd(CT, ack);
      bsr_host_inst.ack_clocks(held);
      chk("second ack", 16'h0001, 16'(ack & held));
      bsr_host_inst.send_reset();
      chk("dout after reset in conversion", 16'h0000, 16'(dout));
      mclk_run = 1'b1;
      $display("test mclk_stop done");
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      error_cnt = 0;
      compares  = 0;
      rst_b     = 1'b0;
      mclk_run  = 1'b1;
      raw_p     = 16'hb3c5;
      raw_t     = 16'h4a61;
      repeat (2) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      t_bad_code();
      t_calib();
      t_conv();
      t_pause();
      t_reset_mid();
      t_mclk_stop();
      tally_and_finish();
   end
endmodule
`default_nettype wire
